//--- rtl/ssup_map.vh
// register map, field positions, defaults and timing counts
//
// Contract
// - boot checks both storages before supervision
// - boot loads all defaults from nonvolatile memory
// - after boot, supervise and accept serial writes
// - first SPI byte out is main status
// - pins show harvester-low and storage-low directly
// - status bit 7 flags nonvolatile write busy
// - status bit 6 flags current measurement running
// - status bit 5 flags harvester energy too low
// - status bit 4 long storage below minimum
// - status bit 3 boost charging long storage
// - status bit 2 storages internally joined
// - status bit 1 external USB power detected
// - status bit 0 long storage protection active
// - voltage bits set when strictly above threshold
// - app maximum clamps to storage maximum
// - split or joined upper minimum by connection
// - threshold equals step times code plus one
// - storage-low pin needs two equal measurements
// - during boot first low measurement asserts pin
// - below lower minimum, enter protection mode
// - level step is 73 mV per code
`ifndef SSUP_MAP_VH
`define SSUP_MAP_VH

// ********************************
// register offsets (7-bit address)
// ********************************
`define SSUP_ADDR_MAIN_STATUS 7'h22
`define SSUP_ADDR_VOLT_STATUS 7'h23
`define SSUP_ADDR_CFG_BASE    7'h06
`define SSUP_ADDR_NVM_COMMIT  7'h0E
`define SSUP_CFG_N            8

// ********************************
// configuration slot indexes
// ********************************
`define SSUP_IDX_SPLIT   3'h0
`define SSUP_IDX_JOINED  3'h1
`define SSUP_IDX_MIN_LO  3'h2
`define SSUP_IDX_SMAX_UP 3'h3
`define SSUP_IDX_SMAX_LO 3'h4
`define SSUP_IDX_AMAX_UP 3'h5
`define SSUP_IDX_AMAX_LO 3'h6
`define SSUP_IDX_MODE    3'h7
`define SSUP_MODE_PRIMARY_BIT 0

// ********************************
// factory defaults and reset values
// ********************************
`define SSUP_DEF_SPLIT   8'h18
`define SSUP_DEF_JOINED  8'h16
`define SSUP_DEF_MIN_LO  8'h12
`define SSUP_DEF_SMAX_UP 8'h35
`define SSUP_DEF_SMAX_LO 8'h33
`define SSUP_DEF_AMAX_UP 8'h30
`define SSUP_DEF_AMAX_LO 8'h2E
`define SSUP_DEF_MODE    8'h00
`define SSUP_STATUS_RST  8'h00

// ********************************
// levels and timing
// ********************************
`define SSUP_LVL_STEP_MV 7'h49
`define SSUP_CLK_KHZ     100000
`define SSUP_NVM_WR_MS   8

`endif

//--- rtl/ssup_sync.v
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module ssup_sync #(
  parameter W = 1
) (
  input  wire         core_clk,
  input  wire         rst_b,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_reg;  // first stage, read by q only

  // plain double register, no logic between stages
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // ssup_sync

//--- rtl/ssup_cmp.v
// one threshold comparator, sampled on each supervision measurement
`timescale 1ns/1ns
module ssup_cmp #(
  parameter [6:0] STEP = 7'h49
) (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        stb,
  input  wire [5:0]  code,
  input  wire [12:0] meas_mv,
  output reg         above
);

  wire [6:0]  code_p1;  // register code plus one
  wire [13:0] thr_mv;   // threshold in millivolts

  assign code_p1 = {1'b0, code} + 7'h01;
  assign thr_mv  = code_p1 * STEP;

  // strictly above; equal counts as not above
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      above <= 1'b0;
    end else if (stb) begin
      above <= ({1'b0, meas_mv} > thr_mv);
    end
  end

endmodule // ssup_cmp

//--- rtl/ssup_top.v
// storage supervisor: boot load, threshold compare, status and SPI access
`timescale 1ns/1ns
`include "ssup_map.vh"
module ssup_top #(
  parameter NVM_WR_CYC = `SSUP_NVM_WR_MS * `SSUP_CLK_KHZ,
  parameter CW         = 20
) (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        spi_sclk,
  input  wire        spi_cs,
  input  wire        spi_mosi,
  output wire        spi_miso,
  input  wire        usb_detect,
  input  wire        meas_valid,
  input  wire [12:0] lts_mv,
  input  wire [12:0] sts_mv,
  input  wire        hrv_low_in,
  input  wire        lux_busy,
  input  wire        boost_long_in,
  input  wire        joined_in,
  output reg         harvester_low_pin,
  output reg         storage_low_pin,
  output reg         protect_active,
  output reg         boot_done
);

  // ********************************
  // states
  // ********************************
  localparam [2:0] ST_LOAD  = 3'h1;  // copy defaults from nvm
  localparam [2:0] ST_CHECK = 3'h2;  // wait first storage check
  localparam [2:0] ST_RUN   = 3'h4;  // normal supervision

  // ********************************
  // declarations
  // ********************************
  reg  [7:0]    nvm_mem [0:`SSUP_CFG_N-1];  // nonvolatile image
  reg  [7:0]    cfg_mem [0:`SSUP_CFG_N-1];  // live configuration
  reg  [2:0]    state_reg;                  // boot/run state
  reg  [2:0]    load_idx_reg;               // boot copy index
  reg  [CW-1:0] nvm_cnt_reg;                // write busy countdown
  reg  [7:0]    status_reg;                 // main status
  reg           meas_d_reg;                 // compare results fresh
  reg           valid_seen_reg;             // one measurement done
  reg           last_below_reg;             // previous sample low
  reg           sclk_prev_reg;              // for edge detection
  reg  [2:0]    bit_cnt_reg;                // bits in current byte
  reg           first_reg;                  // address byte phase
  reg  [7:0]    rx_reg;                     // receive shifter
  reg  [7:0]    tx_reg;                     // transmit shifter
  reg  [6:0]    addr_reg;                   // current address
  reg           wr_reg;                     // frame is a write
  reg  [7:0]    rd_data;                    // read mux
  wire [3:0]    pin_s;                      // synced pins
  wire          sclk_s;
  wire          cs_s;
  wire          mosi_s;
  wire          usb_s;
  wire          sclk_rise;
  wire          sclk_fall;
  wire [7:0]    rx_byte;
  wire          wr_stb;
  wire          commit_stb;
  wire          nvm_busy;
  wire          in_cfg;
  wire [6:0]    cfg_off;
  wire [2:0]    cfg_idx;
  wire          meas_stb;
  wire [7:0]    above;                      // voltage status
  wire [47:0]   codes;                      // eight 6-bit codes
  wire [5:0]    min_up_eff;
  wire [5:0]    amax_up_eff;
  wire [5:0]    amax_lo_eff;
  wire          primary_mode;
  wire          bat_low_calc;
  wire          below;
  integer       i, j;

  // ********************************
  // input synchronisers
  // ********************************
  // spi pins and usb detector come from outside the clock domain
  ssup_sync #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .d        ({spi_sclk, spi_cs, spi_mosi, usb_detect}),
    .q        (pin_s)
  );

  assign sclk_s = pin_s[3];
  assign cs_s   = pin_s[2];
  assign mosi_s = pin_s[1];
  assign usb_s  = pin_s[0];

  // ********************************
  // default image
  // ********************************
  // factory content of the nonvolatile store
  function [7:0] dflt;
    input [2:0] idx;
    begin
      case (idx)
        `SSUP_IDX_SPLIT:   dflt = `SSUP_DEF_SPLIT;
        `SSUP_IDX_JOINED:  dflt = `SSUP_DEF_JOINED;
        `SSUP_IDX_MIN_LO:  dflt = `SSUP_DEF_MIN_LO;
        `SSUP_IDX_SMAX_UP: dflt = `SSUP_DEF_SMAX_UP;
        `SSUP_IDX_SMAX_LO: dflt = `SSUP_DEF_SMAX_LO;
        `SSUP_IDX_AMAX_UP: dflt = `SSUP_DEF_AMAX_UP;
        `SSUP_IDX_AMAX_LO: dflt = `SSUP_DEF_AMAX_LO;
        default:           dflt = `SSUP_DEF_MODE;
      endcase
    end
  endfunction

  // ********************************
  // boot state machine
  // ********************************
  // load runs one slot per cycle, then waits for the first
  // measurement of both storages before normal supervision
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ST_LOAD;
      load_idx_reg <= 3'h0;
      boot_done    <= 1'b0;
    end else begin
      case (state_reg)
        ST_LOAD: begin
          load_idx_reg <= load_idx_reg + 3'h1;
          if (load_idx_reg == 3'h7) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // first storage check ends boot
          if (meas_d_reg) begin
            state_reg <= ST_RUN;
            boot_done <= 1'b1;
          end
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_LOAD;
        end
      endcase
    end
  end

  // ********************************
  // configuration and nonvolatile store
  // ********************************
  assign cfg_off  = addr_reg - `SSUP_ADDR_CFG_BASE;
  assign cfg_idx  = cfg_off[2:0];
  assign in_cfg   = (addr_reg >= `SSUP_ADDR_CFG_BASE) &&
                    (cfg_off < 7'h08);
  assign nvm_busy = (nvm_cnt_reg != {CW{1'b0}});
  // writes ignored while the store is busy; host should wait
  assign commit_stb = wr_stb && (addr_reg == `SSUP_ADDR_NVM_COMMIT)
                      && !nvm_busy;

  // live copy is loaded at boot, then written over the link
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < `SSUP_CFG_N; i = i + 1) begin
        cfg_mem[i] <= 8'h00;
      end
    end else if (state_reg == ST_LOAD) begin
      cfg_mem[load_idx_reg] <= nvm_mem[load_idx_reg];
    end else if (wr_stb && in_cfg && !nvm_busy) begin
      cfg_mem[cfg_idx] <= rx_byte;
    end
  end

  // commit copies the whole live set into the store at once
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (j = 0; j < `SSUP_CFG_N; j = j + 1) begin
        nvm_mem[j] <= dflt(j[2:0]);
      end
    end else if (commit_stb) begin
      for (j = 0; j < `SSUP_CFG_N; j = j + 1) begin
        nvm_mem[j] <= cfg_mem[j];
      end
    end
  end

  // write time model: busy for the full programming time
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nvm_cnt_reg <= {CW{1'b0}};
    end else if (commit_stb) begin
      nvm_cnt_reg <= NVM_WR_CYC[CW-1:0];
    end else if (nvm_busy) begin
      nvm_cnt_reg <= nvm_cnt_reg - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // ********************************
  // threshold selection
  // ********************************
  assign primary_mode = cfg_mem[`SSUP_IDX_MODE][`SSUP_MODE_PRIMARY_BIT];
  // split level while apart, joined level while connected
  assign min_up_eff = joined_in ? cfg_mem[`SSUP_IDX_JOINED][5:0]
                                : cfg_mem[`SSUP_IDX_SPLIT][5:0];
  // app maximum never above storage maximum
  assign amax_up_eff = (cfg_mem[`SSUP_IDX_AMAX_UP][5:0] >=
                        cfg_mem[`SSUP_IDX_SMAX_UP][5:0]) ?
                       cfg_mem[`SSUP_IDX_SMAX_UP][5:0] :
                       cfg_mem[`SSUP_IDX_AMAX_UP][5:0];
  assign amax_lo_eff = (cfg_mem[`SSUP_IDX_AMAX_LO][5:0] >=
                        cfg_mem[`SSUP_IDX_SMAX_LO][5:0]) ?
                       cfg_mem[`SSUP_IDX_SMAX_LO][5:0] :
                       cfg_mem[`SSUP_IDX_AMAX_LO][5:0];
  // bit order of the voltage status register
  assign codes = {min_up_eff,
                  cfg_mem[`SSUP_IDX_MIN_LO][5:0],
                  cfg_mem[`SSUP_IDX_SMAX_UP][5:0],
                  cfg_mem[`SSUP_IDX_SMAX_LO][5:0],
                  amax_up_eff,
                  amax_lo_eff,
                  min_up_eff,
                  cfg_mem[`SSUP_IDX_MIN_LO][5:0]};

  // ********************************
  // comparators
  // ********************************
  // thresholds are not valid during load, so samples are ignored
  assign meas_stb = meas_valid && (state_reg != ST_LOAD);

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_cmp
      ssup_cmp #(
        .STEP (`SSUP_LVL_STEP_MV)
      ) u_cmp (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .stb      (meas_stb),
        .code     (codes[g*6+5:g*6]),
        .meas_mv  ((g >= 6) ? lts_mv : sts_mv),
        .above    (above[g])
      );
    end
  endgenerate

  // ********************************
  // supervision outcome
  // ********************************
  // primary cell mode judges status bit 4 against the lower minimum; the storage-low pin stays on the upper one
  assign bat_low_calc = primary_mode ? ~above[6] : ~above[7];
  assign below        = ~above[7];

  // results are fresh one cycle after the sample strobe
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meas_d_reg     <= 1'b0;
      valid_seen_reg <= 1'b0;
      last_below_reg <= 1'b0;
      storage_low_pin <= 1'b0;
      protect_active <= 1'b0;
    end else begin
      meas_d_reg <= meas_stb;
      if (meas_d_reg) begin
        valid_seen_reg <= 1'b1;
        last_below_reg <= below;
        protect_active <= ~above[6];
        if (state_reg == ST_CHECK) begin
          // one sample is enough while booting
          storage_low_pin <= below;
        end else if (below && last_below_reg) begin
          storage_low_pin <= 1'b1;
        end else if (!below && !last_below_reg) begin
          storage_low_pin <= 1'b0;
        end
      end
    end
  end

  // harvester state shown on its pin without a register read
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      harvester_low_pin <= 1'b0;
    end else begin
      harvester_low_pin <= hrv_low_in;
    end
  end

  // ********************************
  // main status
  // ********************************
  // live bits each cycle; compare bits move per sample, bit 4 also on a mode write
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= `SSUP_STATUS_RST;
    end else begin
      status_reg <= {nvm_busy,
                     lux_busy,
                     hrv_low_in,
                     valid_seen_reg & bat_low_calc,
                     boost_long_in,
                     joined_in,
                     usb_s,
                     valid_seen_reg & ~above[6]};
    end
  end

  // ********************************
  // spi slave (mode 0, cs active high)
  // ********************************
  assign sclk_rise = cs_s && sclk_s && !sclk_prev_reg;
  assign sclk_fall = cs_s && !sclk_s && sclk_prev_reg;
  assign rx_byte   = {rx_reg[6:0], mosi_s};
  // data bytes only; config is locked until boot finishes
  assign wr_stb    = sclk_rise && (bit_cnt_reg == 3'h7) && !first_reg
                     && wr_reg && (state_reg == ST_RUN);
  assign spi_miso  = tx_reg[7];

  // read mux; reads have no side effect on any bit
  always @* begin
    rd_data = 8'h00;
    if (addr_reg == `SSUP_ADDR_MAIN_STATUS) begin
      rd_data = status_reg;
    end else if (addr_reg == `SSUP_ADDR_VOLT_STATUS) begin
      rd_data = above;
    end else if (in_cfg) begin
      rd_data = cfg_mem[cfg_idx];
    end
  end

  // byte framing: first byte is address, rest are data with
  // auto increment so a whole set fits in one frame
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_reg <= 1'b0;
      bit_cnt_reg   <= 3'h0;
      first_reg     <= 1'b1;
      rx_reg        <= 8'h00;
      tx_reg        <= 8'h00;
      addr_reg      <= 7'h00;
      wr_reg        <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
      if (!cs_s) begin
        // idle: keep status ready so its msb leads the frame
        bit_cnt_reg <= 3'h0;
        first_reg   <= 1'b1;
        tx_reg      <= status_reg;
      end else if (sclk_rise) begin
        rx_reg      <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          if (first_reg) begin
            addr_reg  <= rx_byte[6:0];
            wr_reg    <= rx_byte[7];
            first_reg <= 1'b0;
          end else begin
            addr_reg <= addr_reg + 7'h01;
          end
        end
      end else if (sclk_fall) begin
        if ((bit_cnt_reg == 3'h0) && !first_reg) begin
          tx_reg <= rd_data;
        end else begin
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

endmodule // ssup_top

//--- testbench/ssup_top_assertions.sv
// concurrent checks on the storage supervisor ports
`timescale 1ns/1ns
module ssup_top_chk #(
  parameter NVM_WR_CYC = 800000,
  parameter CW         = 20
) (
  input wire        core_clk,
  input wire        rst_b,
  input wire        spi_sclk,
  input wire        spi_cs,
  input wire        spi_mosi,
  input wire        spi_miso,
  input wire        usb_detect,
  input wire        meas_valid,
  input wire [12:0] lts_mv,
  input wire [12:0] sts_mv,
  input wire        hrv_low_in,
  input wire        lux_busy,
  input wire        boost_long_in,
  input wire        joined_in,
  input wire        harvester_low_pin,
  input wire        storage_low_pin,
  input wire        protect_active,
  input wire        boot_done
);
  // ****************
  // helper state
  // ****************
  // default lower, joined and split minimum levels in mV; the bench never rewrites them
  localparam [12:0] MIN_LO   = 13'h056B;
  localparam [12:0] JOIN_UP  = 13'h068F;
  localparam [12:0] SPLIT_UP = 13'h0721;
  wire       below = lts_mv <= (joined_in ? JOIN_UP : SPLIT_UP); // effective upper minimum
  reg        prev_below_reg;                                     // verdict of previous sample
  reg        lo_seen_reg;                                        // last sample at or below lower minimum
  reg  [3:0] age_reg;                                            // edges since reset, saturating
  // track sample verdicts and time since reset
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_below_reg <= 1'b0;
      lo_seen_reg    <= 1'b0;
      age_reg        <= 4'h0;
    end else begin
      if (meas_valid) begin
        prev_below_reg <= below;
        lo_seen_reg    <= (lts_mv <= MIN_LO);
      end
      if (age_reg != 4'hF) begin
        age_reg <= age_reg + 4'h1;
      end
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_boot_load_time: assert property (
    age_reg < 4'h9 |-> !boot_done) else $error("boot ended during default load");
  chk_boot_stays: assert property (
    boot_done |=> boot_done) else $error("boot done dropped");
  chk_boot_ends: assert property (
    meas_valid && !boot_done && age_reg > 4'h8 |-> ##[1:4] boot_done)
    else $error("boot did not end on first sample");
  chk_boot_first_low: assert property (
    meas_valid && !boot_done && age_reg > 4'h8 && below |-> ##[2:3] storage_low_pin)
    else $error("first low sample in boot did not set pin");
  chk_low_assert: assert property (
    meas_valid && boot_done && below && prev_below_reg |-> ##[2:3] storage_low_pin)
    else $error("two low samples did not set pin");
  chk_low_release: assert property (
    meas_valid && boot_done && !below && !prev_below_reg |-> ##[2:3] !storage_low_pin)
    else $error("two high samples did not clear pin");
  chk_low_hold: assert property (
    meas_valid && boot_done && (below != prev_below_reg) |-> ##1 $stable(storage_low_pin)[*3])
    else $error("pin moved on a single sample");
  chk_protect_level: assert property (
    meas_valid && age_reg > 4'h8 |-> ##[2:3] protect_active == lo_seen_reg)
    else $error("protection flag wrong for sample");
  chk_pins_on_meas: assert property (
    $changed(storage_low_pin) || $changed(protect_active)
      |-> $past(meas_valid, 2) || $past(meas_valid, 3)) else $error("pin moved without sample");
  chk_harv_pin_copy: assert property (
    harvester_low_pin == $past(hrv_low_in)) else $error("harvester pin not following input");
endmodule // ssup_top_chk

bind ssup_top ssup_top_chk #(.NVM_WR_CYC(NVM_WR_CYC), .CW(CW)) i_chk (
  .core_clk(core_clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs(spi_cs),
  .spi_mosi(spi_mosi), .spi_miso(spi_miso), .usb_detect(usb_detect),
  .meas_valid(meas_valid), .lts_mv(lts_mv), .sts_mv(sts_mv), .hrv_low_in(hrv_low_in),
  .lux_busy(lux_busy), .boost_long_in(boost_long_in), .joined_in(joined_in),
  .harvester_low_pin(harvester_low_pin), .storage_low_pin(storage_low_pin),
  .protect_active(protect_active), .boot_done(boot_done));

//--- testbench/ssup_host_model.sv
// host controller model: SPI master running frames into the supervisor
`timescale 1ns/1ns
module ssup_host_model (
  input  wire  core_clk,
  input  wire  spi_miso,
  output logic spi_sclk,
  output logic spi_cs,
  output logic spi_mosi
);
  // ****************
  // frame engine
  // ****************
  // link clock idles low and stands still between frames
  initial begin
    spi_sclk = 1'b0;
    spi_cs   = 1'b0;
    spi_mosi = 1'b0;
  end
  // command byte then nb data bytes (1 or 2), MSB first, half period of 40 ns;
  // a configuration update of one or two neighbouring bytes goes out in one frame
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] wd,
                      input int nb, output logic [7:0] st, output logic [7:0] rd);
    logic [23:0] tx;
    logic [23:0] rx;
    int          k;
    tx = {wr, a, wd};
    rx = 24'h000000;
    @(negedge core_clk);
    spi_cs = 1'b1;
    repeat (8) @(negedge core_clk);
    for (k = 23; k >= 16 - 8 * nb; k--) begin
      spi_mosi = tx[k];
      repeat (4) @(negedge core_clk);
      spi_sclk = 1'b1;
      rx[k] = spi_miso;
      repeat (4) @(negedge core_clk);
      spi_sclk = 1'b0;
    end
    repeat (4) @(negedge core_clk);
    spi_cs = 1'b0;
    // released data line must not keep looking valid
    spi_mosi = ~spi_mosi;
    repeat (8) @(negedge core_clk);
    st = rx[23:16];
    rd = rx[15:8];
  endtask
endmodule // ssup_host_model

//--- testbench/tb_ssup_top.sv
// self-checking bench for the storage supervisor
`timescale 1ns/1ns
module tb_ssup_top;
  // ****************
  // signals
  // ****************
  logic        core_clk, rst_b, usb_detect, meas_valid;   // clock, reset, plain inputs
  logic        hrv_low_in, lux_busy, boost_long_in, joined_in;
  logic [12:0] lts_mv, sts_mv;                           // sampled storage voltages
  wire         spi_sclk, spi_cs, spi_mosi, spi_miso;     // link between host and block
  wire         harvester_low_pin, storage_low_pin, protect_active, boot_done;
  logic [7:0]  st, rd;                                   // status and data byte of a frame
  int          miscompares, comparisons;
  ssup_top #(.NVM_WR_CYC(400)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs(spi_cs),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .usb_detect(usb_detect),
    .meas_valid(meas_valid), .lts_mv(lts_mv), .sts_mv(sts_mv), .hrv_low_in(hrv_low_in),
    .lux_busy(lux_busy), .boost_long_in(boost_long_in), .joined_in(joined_in),
    .harvester_low_pin(harvester_low_pin), .storage_low_pin(storage_low_pin),
    .protect_active(protect_active), .boot_done(boot_done));
  ssup_host_model i_host (.core_clk(core_clk), .spi_miso(spi_miso), .spi_sclk(spi_sclk),
    .spi_cs(spi_cs), .spi_mosi(spi_mosi));
  // ****************
  // tasks
  // ****************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer(1'b1, a, {d, 8'h00}, 1, st, rd);
  endtask
  // two neighbouring configuration bytes in one frame
  task automatic wr2(input logic [6:0] a, input logic [7:0] d0, input logic [7:0] d1);
    i_host.xfer(1'b1, a, {d0, d1}, 2, st, rd);
  endtask
  task automatic rdr(input logic [6:0] a);
    i_host.xfer(1'b0, a, 16'h0000, 1, st, rd);
  endtask
  // one sample pulse, then enough cycles for status to settle
  task automatic meas(input logic [12:0] l, input logic [12:0] s);
    @(negedge core_clk);
    lts_mv = l;
    sts_mv = s;
    meas_valid = 1'b1;
    @(negedge core_clk);
    meas_valid = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************
  // clock and watchdog
  // ****************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // the sequence needs about 3000 cycles; a hang is cut well after that
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
  // ****************
  // main sequence; thresholds stay ordered, split minimum untouched
  // ****************
  initial begin
    {rst_b, usb_detect, meas_valid, hrv_low_in, lux_busy, boost_long_in} = 6'h00;
    joined_in = 1'b1;
    lts_mv = 13'h0000;
    sts_mv = 13'h0000;
    miscompares = 0;
    comparisons = 0;
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    wr(7'h0B, 8'h11);                                   // dropped, boot not finished
    check({7'h00, boot_done}, 8'h00);
    meas(13'h03E8, 13'h03E8);                           // 1000 mV ends boot
    check({6'h00, boot_done, storage_low_pin}, 8'h03);
    check({7'h00, protect_active}, 8'h01);
    rdr(7'h0B);
    check(rd, 8'h30);
    check(st, 8'h15);
    rdr(7'h0D);
    check(rd, 8'h00);
    wr2(7'h0B, 8'h2A, 8'h29);                           // app maximum pair, upper above lower
    rdr(7'h0B);
    check(rd, 8'h2A);
    rdr(7'h0C);
    check(rd, 8'h29);
    {usb_detect, hrv_low_in, lux_busy, boost_long_in} = 4'hF;
    meas(13'h0BB8, 13'h0ED4);                           // sts exactly on max lower level
    check({7'h00, storage_low_pin}, 8'h01);
    meas(13'h0BB8, 13'h0ED4);
    check({6'h00, storage_low_pin, protect_active}, 8'h00);
    check({7'h00, harvester_low_pin}, 8'h01);
    rdr(7'h23);
    check(st, 8'h6E);
    check(rd, 8'hCF);
    rdr(7'h23);
    check(rd, 8'hCF);
    wr(7'h0B, 8'h3F);                                   // app maximum above storage maximum
    meas(13'h0BB8, 13'h0FA0);
    rdr(7'h23);
    check(rd, 8'hFF);
    {usb_detect, hrv_low_in, lux_busy, boost_long_in, joined_in} = 5'h00;
    meas(13'h06D6, 13'h06D6);                           // between joined and split minimum
    meas(13'h06D6, 13'h06D6);
    check({7'h00, storage_low_pin}, 8'h01);
    rdr(7'h23);
    check(st, 8'h10);
    check(rd, 8'h41);
    wr(7'h0D, 8'h01);                                   // primary cell mode
    meas(13'h06D6, 13'h06D6);
    rdr(7'h23);
    check(st, 8'h00);
    check({7'h00, storage_low_pin}, 8'h01);
    wr(7'h0E, 8'h00);                                   // commit starts a memory write
    rdr(7'h22);
    check(rd, 8'h80);
    wr(7'h0B, 8'h05);                                   // dropped while memory busy
    repeat (400) @(negedge core_clk);
    rdr(7'h0B);
    check(rd, 8'h3F);
    check(st, 8'h00);
    rdr(7'h50);
    check(rd, 8'h00);
    conclude();
  end
endmodule // tb_ssup_top
